// >>> hdl/motion_detect_pkg.sv
package motion_detect_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_Y_LOW = 8'h10;
   localparam logic [7:0] OFS_Y_HIGH = 8'h11;
   localparam logic [7:0] OFS_Z_LOW = 8'h12;
   localparam logic [7:0] OFS_Z_HIGH = 8'h13;
   localparam logic [7:0] OFS_TEMP_LOW = 8'h14;
   localparam logic [7:0] OFS_TEMP_HIGH = 8'h15;
   localparam logic [7:0] OFS_AUX_LOW = 8'h16;
   localparam logic [7:0] OFS_AUX_HIGH = 8'h17;
   localparam logic [7:0] OFS_SOFT_RESET = 8'h1F;
   localparam logic [7:0] OFS_ACT_LIMIT_LOW = 8'h20;
   localparam logic [7:0] OFS_ACT_LIMIT_HIGH = 8'h21;
   localparam logic [7:0] OFS_ACT_DURATION = 8'h22;
   localparam logic [7:0] OFS_STILL_LIMIT_LOW = 8'h23;
   localparam logic [7:0] OFS_STILL_LIMIT_HIGH = 8'h24;
   localparam logic [7:0] OFS_STILL_DUR_LOW = 8'h25;
   localparam logic [7:0] OFS_STILL_DUR_HIGH = 8'h26;

   // ---------------------------------------------------------------
   // Codes, field positions and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_WRITE = 8'h0A;
   localparam logic [7:0] CMD_READ = 8'h0B;
   localparam logic [7:0] SOFT_RESET_CODE = 8'h52;
   localparam logic [7:0] READ_ZERO = 8'h00;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int SIGN_BIT = 11;
   localparam int LIMIT_MSB = 10;
   localparam logic [7:0] MIN_ACT_COUNT = 8'h01;
   localparam logic [15:0] MIN_STILL_COUNT = 16'h0001;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [11:0] x;
      logic [11:0] y;
      logic [11:0] z;
      logic [11:0] temp;
      logic [11:0] aux;
   } sample_t;

   typedef struct packed {
      logic [10:0] act_limit;
      logic [7:0] act_duration;
      logic [10:0] still_limit;
      logic [15:0] still_duration;
   } detect_cfg_t;

endpackage : motion_detect_pkg

// >>> hdl/motion_detect_register_bank.sv
// Functional notes
// - Z result is 12-bit, low/high byte pair
// - High byte bits 15:12 copy bit 11
// - Y result pair at 0x10 and 0x11
// - Temperature result 12-bit sign extended
// - Aux converter result at 0x16/0x17
// - Writing 0x52 to 0x1F resets immediately
// - Soft reset clears settings, enters standby
// - Soft reset floats interrupt pins with keepers
// - Reset register is write-only, reads 0x00
// - Activity compares axis magnitude to 11-bit limit
// - Activity limit from 0x20 low, 0x21 high
// - Activity needs programmed consecutive qualifying samples
// - Activity count zero behaves like one
// - Wake-up mode uses single sample for activity
// - Stillness limit from 0x23 and 0x24
// - Stillness needs 16-bit consecutive quiet samples
// - Stillness count from low and high bytes
// - Counts advance once per output sample
// - All bank registers reset to 0x00
// - Stillness count zero behaves like one
// - Activity detection only while enabled
module motion_detect_register_bank
   import motion_detect_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic SPI_SCLK,
   input wire logic SPI_CS_N,
   input wire logic SPI_MOSI,
   output logic SPI_MISO_O,
   output logic SPI_MISO_OE,
   input wire logic SAMPLE_STB,
   input wire sample_t SAMPLE,
   input wire logic ACT_ENABLE,
   input wire logic STILL_ENABLE,
   input wire logic WAKEUP_MODE,
   input wire logic MEASURE_START,
   input wire logic INT_RELEASE,
   output logic ACTIVITY_EVT,
   output logic STILLNESS_EVT,
   output logic SOFT_RESET_EVT,
   output logic STANDBY,
   output logic INT_HIZ
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // Bit order: sclk, cs_n, mosi
   logic [2:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
   logic [2:0] pin_lvl_reg, pin_prev_reg;
   wire [2:0] pin_raw = {SPI_SCLK, SPI_CS_N, SPI_MOSI};
   wire [2:0] pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
   wire [2:0] pin_lvl_next = (pin_agree & pin_s3_reg) | (~pin_agree & pin_lvl_reg);

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         // Idle levels: clock low, select high, so no false edge follows reset
         pin_s1_reg <= 3'h2;
         pin_s2_reg <= 3'h2;
         pin_s3_reg <= 3'h2;
         pin_lvl_reg <= 3'h2;
         pin_prev_reg <= 3'h2;
      end else begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         pin_lvl_reg <= pin_lvl_next;
         pin_prev_reg <= pin_lvl_reg;
      end
   end

   wire cs_act = ~pin_lvl_reg[1];
   wire sclk_rise = cs_act & pin_lvl_reg[2] & ~pin_prev_reg[2];
   wire sclk_fall = cs_act & ~pin_lvl_reg[2] & pin_prev_reg[2];
   wire mosi_lvl = pin_lvl_reg[0];

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   sample_t res_reg;
   detect_cfg_t cfg_reg;

   function automatic logic [7:0] high_byte(input logic [11:0] v);
      high_byte = {{4{v[SIGN_BIT]}}, v[11:8]};
   endfunction : high_byte

   function automatic logic [11:0] magnitude(input logic [11:0] v);
      magnitude = v[SIGN_BIT] ? 12'(-v) : v;
   endfunction : magnitude

   // Read decode; unmapped offsets and the reset register read zero
   function automatic logic [7:0] rd_byte(input logic [7:0] a, input sample_t r,
                                         input detect_cfg_t c);
      case (a)
         OFS_Y_LOW: rd_byte = r.y[7:0];
         OFS_Y_HIGH: rd_byte = high_byte(r.y);
         OFS_Z_LOW: rd_byte = r.z[7:0];
         OFS_Z_HIGH: rd_byte = high_byte(r.z);
         OFS_TEMP_LOW: rd_byte = r.temp[7:0];
         OFS_TEMP_HIGH: rd_byte = high_byte(r.temp);
         OFS_AUX_LOW: rd_byte = r.aux[7:0];
         OFS_AUX_HIGH: rd_byte = high_byte(r.aux);
         OFS_SOFT_RESET: rd_byte = READ_ZERO;
         OFS_ACT_LIMIT_LOW: rd_byte = c.act_limit[7:0];
         OFS_ACT_LIMIT_HIGH: rd_byte = {5'h00, c.act_limit[LIMIT_MSB:8]};
         OFS_ACT_DURATION: rd_byte = c.act_duration;
         OFS_STILL_LIMIT_LOW: rd_byte = c.still_limit[7:0];
         OFS_STILL_LIMIT_HIGH: rd_byte = {5'h00, c.still_limit[LIMIT_MSB:8]};
         OFS_STILL_DUR_LOW: rd_byte = c.still_duration[7:0];
         OFS_STILL_DUR_HIGH: rd_byte = c.still_duration[15:8];
         default: rd_byte = READ_ZERO;
      endcase
   endfunction : rd_byte

   // ---------------------------------------------------------------
   // Serial port engine
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_CMD = 3'b001,
      ST_ADDR = 3'b010,
      ST_DATA = 3'b100
   } spi_state_t;

   spi_state_t st_reg, st_next;
   logic [2:0] bit_cnt_reg;
   logic [6:0] shift_reg;
   logic [7:0] cmd_reg, addr_reg, tx_reg;
   logic miso_reg;

   wire byte_done = sclk_rise & (bit_cnt_reg == 3'h7);
   wire [7:0] rx_byte = {shift_reg, mosi_lvl};
   wire is_read = (cmd_reg == CMD_READ);
   wire wr_en = byte_done & (st_reg == ST_DATA) & (cmd_reg == CMD_WRITE);
   wire tx_load = byte_done & is_read & (st_reg != ST_CMD);
   wire [7:0] tx_addr = (st_reg == ST_ADDR) ? rx_byte : 8'(addr_reg + 8'h01);
   wire [7:0] addr_next = (st_reg == ST_ADDR) ? rx_byte : 8'(addr_reg + 8'h01);

   always_comb begin
      st_next = st_reg;
      if (byte_done) begin
         unique case (st_reg)
            ST_CMD: st_next = ST_ADDR;
            ST_ADDR: st_next = ST_DATA;
            ST_DATA: st_next = ST_DATA;
         endcase
      end
   end

   // Engine is not cleared by a soft reset: the host frame ends normally
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_reg <= ST_CMD;
         bit_cnt_reg <= 3'h0;
         shift_reg <= 7'h00;
         cmd_reg <= 8'h00;
         addr_reg <= 8'h00;
      end else if (!cs_act) begin
         st_reg <= ST_CMD;
         bit_cnt_reg <= 3'h0;
      end else if (sclk_rise) begin
         st_reg <= st_next;
         bit_cnt_reg <= 3'(bit_cnt_reg + 3'h1);
         shift_reg <= rx_byte[6:0];
         if (byte_done && st_reg == ST_CMD) begin
            cmd_reg <= rx_byte;
         end
         if (byte_done && st_reg != ST_CMD) begin
            addr_reg <= addr_next;
         end
      end
   end

   // Output changes on falling edge so it is stable for the host's rising edge
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tx_reg <= 8'h00;
         miso_reg <= 1'b0;
      end else if (tx_load) begin
         tx_reg <= rd_byte(tx_addr, res_reg, cfg_reg);
      end else if (sclk_fall && is_read && st_reg == ST_DATA) begin
         miso_reg <= tx_reg[7];
         tx_reg <= {tx_reg[6:0], 1'b0};
      end
   end

   assign SPI_MISO_O = miso_reg;
   assign SPI_MISO_OE = cs_act;

   // ---------------------------------------------------------------
   // Writes and soft reset
   // ---------------------------------------------------------------
   wire soft_clr = wr_en & (addr_reg == OFS_SOFT_RESET) & (rx_byte == SOFT_RESET_CODE);
   wire sample_take = SAMPLE_STB & ~STANDBY;

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_reg <= '0;
      end else if (soft_clr) begin
         cfg_reg <= '0;
      end else if (wr_en) begin
         case (addr_reg)
            OFS_ACT_LIMIT_LOW: cfg_reg.act_limit[7:0] <= rx_byte;
            OFS_ACT_LIMIT_HIGH: cfg_reg.act_limit[LIMIT_MSB:8] <= rx_byte[2:0];
            OFS_ACT_DURATION: cfg_reg.act_duration <= rx_byte;
            OFS_STILL_LIMIT_LOW: cfg_reg.still_limit[7:0] <= rx_byte;
            OFS_STILL_LIMIT_HIGH: cfg_reg.still_limit[LIMIT_MSB:8] <= rx_byte[2:0];
            OFS_STILL_DUR_LOW: cfg_reg.still_duration[7:0] <= rx_byte;
            OFS_STILL_DUR_HIGH: cfg_reg.still_duration[15:8] <= rx_byte;
            default: cfg_reg <= cfg_reg;
         endcase
      end
   end

   // Whole sample latched in one edge; a burst read loads each byte from res_reg separately, so a sample between bytes mixes halves
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         res_reg <= '0;
      end else if (soft_clr) begin
         res_reg <= '0;
      end else if (sample_take) begin
         res_reg <= SAMPLE;
      end
   end

   // Standby and floating interrupt pins hold until the system releases them
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         STANDBY <= 1'b1;
         INT_HIZ <= 1'b1;
         SOFT_RESET_EVT <= 1'b0;
      end else begin
         SOFT_RESET_EVT <= soft_clr;
         if (soft_clr) begin
            STANDBY <= 1'b1;
            INT_HIZ <= 1'b1;
         end else begin
            if (MEASURE_START) begin
               STANDBY <= 1'b0;
            end
            if (INT_RELEASE) begin
               INT_HIZ <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Motion detection
   // ---------------------------------------------------------------
   wire [11:0] mag_x = magnitude(SAMPLE.x);
   wire [11:0] mag_y = magnitude(SAMPLE.y);
   wire [11:0] mag_z = magnitude(SAMPLE.z);
   wire [11:0] act_lim = {1'b0, cfg_reg.act_limit};
   wire [11:0] still_lim = {1'b0, cfg_reg.still_limit};
   wire act_hit = (mag_x > act_lim) | (mag_y > act_lim) | (mag_z > act_lim);
   wire still_hit = (mag_x < still_lim) & (mag_y < still_lim) & (mag_z < still_lim);
   wire act_short = WAKEUP_MODE | (cfg_reg.act_duration == 8'h00);
   wire [7:0] act_target = act_short ? MIN_ACT_COUNT : cfg_reg.act_duration;
   wire [15:0] still_target = (cfg_reg.still_duration == 16'h0000) ? MIN_STILL_COUNT :
                              cfg_reg.still_duration;

   logic [7:0] act_cnt_reg;
   logic [15:0] still_cnt_reg;
   wire act_qual = ACT_ENABLE & act_hit;
   wire still_qual = STILL_ENABLE & still_hit;
   wire act_fire = sample_take & act_qual &
                   ({1'b0, act_cnt_reg} + 9'h001 == {1'b0, act_target});
   wire still_fire = sample_take & still_qual &
                     ({1'b0, still_cnt_reg} + 17'h00001 == {1'b0, still_target});

   // Counters stop at the target, so one sustained run gives one event
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         act_cnt_reg <= 8'h00;
         still_cnt_reg <= 16'h0000;
         ACTIVITY_EVT <= 1'b0;
         STILLNESS_EVT <= 1'b0;
      end else if (soft_clr) begin
         act_cnt_reg <= 8'h00;
         still_cnt_reg <= 16'h0000;
         ACTIVITY_EVT <= 1'b0;
         STILLNESS_EVT <= 1'b0;
      end else begin
         ACTIVITY_EVT <= act_fire;
         STILLNESS_EVT <= still_fire;
         if (sample_take) begin
            if (!act_qual) begin
               act_cnt_reg <= 8'h00;
            end else if (act_cnt_reg < act_target) begin
               act_cnt_reg <= 8'(act_cnt_reg + 8'h01);
            end
            if (!still_qual) begin
               still_cnt_reg <= 16'h0000;
            end else if (still_cnt_reg < still_target) begin
               still_cnt_reg <= 16'(still_cnt_reg + 16'h0001);
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);

   wire [7:0] z_high_rd = rd_byte(OFS_Z_HIGH, res_reg, cfg_reg);
   wire [7:0] y_high_rd = rd_byte(OFS_Y_HIGH, res_reg, cfg_reg);

   property p_pair_latch;
      sample_take && !soft_clr |=> res_reg == $past(SAMPLE);
   endproperty
   a_pair_latch: assert property (p_pair_latch)
      else $error("result pair not latched as one sample");

   property p_sign_copy;
      z_high_rd[7:4] == {4{res_reg.z[11]}} && y_high_rd[3:0] == res_reg.y[11:8];
   endproperty
   a_sign_copy: assert property (p_sign_copy)
      else $error("high byte sign copy wrong");

   property p_soft_reset;
      soft_clr |=> SOFT_RESET_EVT && cfg_reg == '0 && STANDBY && INT_HIZ;
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("soft reset did not clear bank");

   property p_wrong_code;
      wr_en && addr_reg == OFS_SOFT_RESET && rx_byte != SOFT_RESET_CODE |=> !SOFT_RESET_EVT;
   endproperty
   a_wrong_code: assert property (p_wrong_code)
      else $error("soft reset taken for wrong code");

   property p_reset_reads_zero;
      tx_load && tx_addr == OFS_SOFT_RESET |=> tx_reg == 8'h00;
   endproperty
   a_reset_reads_zero: assert property (p_reset_reads_zero)
      else $error("reset register read not zero");

   property p_single_sample;
      sample_take && act_qual && act_short && act_cnt_reg == 8'h00 && !soft_clr
         |=> ACTIVITY_EVT ##1 !ACTIVITY_EVT;
   endproperty
   a_single_sample: assert property (p_single_sample)
      else $error("single qualifying sample missed");

   property p_act_disabled;
      !ACT_ENABLE |=> !ACTIVITY_EVT;
   endproperty
   a_act_disabled: assert property (p_act_disabled)
      else $error("activity while disabled");

   property p_act_break;
      sample_take && !act_hit |=> act_cnt_reg == 8'h00 && !ACTIVITY_EVT;
   endproperty
   a_act_break: assert property (p_act_break)
      else $error("activity run not broken");

   property p_limit_high;
      wr_en && addr_reg == OFS_ACT_LIMIT_HIGH && !soft_clr
         |=> cfg_reg.act_limit[10:8] == $past(rx_byte[2:0]);
   endproperty
   a_limit_high: assert property (p_limit_high)
      else $error("activity limit high bits wrong");

   property p_still_run;
      sample_take && !still_qual |=> still_cnt_reg == 16'h0000 && !STILLNESS_EVT;
   endproperty
   a_still_run: assert property (p_still_run)
      else $error("stillness run not broken");

   c_activity: cover property (act_fire && cfg_reg.act_duration > 8'h01);
   c_stillness: cover property (still_fire);
   c_soft_reset: cover property (soft_clr);
   c_burst_read: cover property (tx_load && st_reg == ST_DATA);

endmodule : motion_detect_register_bank

// >>> test/spi_host_model.sv
module spi_host_model
   import motion_detect_pkg::*;
(
   input wire logic CORE_CLK,
   output logic SPI_SCLK,
   output logic SPI_CS_N,
   output logic SPI_MOSI,
   input wire logic SPI_MISO_O,
   input wire logic SPI_MISO_OE
);
   timeunit 1ns;
   timeprecision 1ps;
   // Each serial level must stay put well past the device's 3-flop pin filter
   localparam int HALF = 8;
   logic float_bit = 1'b0;
   logic miso_line;

   // -----------------------------
   // Line level
   // -----------------------------
   // A released data line shows a changing value, never the last bit
   always @(posedge CORE_CLK) float_bit <= ~float_bit;
   assign miso_line = SPI_MISO_OE ? SPI_MISO_O : float_bit;

   initial begin
      SPI_SCLK = 1'b0;
      SPI_CS_N = 1'b1;
      SPI_MOSI = 1'b0;
   end

   // -----------------------------
   // Transfers
   // -----------------------------
   task automatic wait_clk(input int n);
      repeat (n) @(posedge CORE_CLK);
   endtask : wait_clk

   task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         SPI_MOSI <= tx[i];
         wait_clk(HALF);
         SPI_SCLK <= 1'b1;
         rx[i] = miso_line;
         wait_clk(HALF);
         SPI_SCLK <= 1'b0;
      end
   endtask : xfer_byte

   // Command, offset, then n data bytes low first; the host sends any reset code it is given
   task automatic frame(input logic [7:0] cmd, input logic [7:0] addr, input int n,
                        input logic [15:0] wdata, output logic [15:0] rdata);
      logic [7:0] rx;
      rdata = 16'h0000;
      SPI_CS_N <= 1'b0;
      wait_clk(HALF);
      xfer_byte(cmd, rx);
      xfer_byte(addr, rx);
      for (int j = 0; j < n; j++) begin
         xfer_byte(j == 0 ? wdata[7:0] : wdata[15:8], rx);
         if (j == 0) begin
            rdata[7:0] = rx;
         end else begin
            rdata[15:8] = rx;
         end
      end
      wait_clk(HALF);
      SPI_CS_N <= 1'b1;
      SPI_MOSI <= ~SPI_MOSI;
      wait_clk(HALF);
   endtask : frame
endmodule : spi_host_model

// >>> test/motion_detect_register_bank_bench.sv
module motion_detect_register_bank_bench
   import motion_detect_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIMIT = 40000;
   logic core_clk = 1'b0;
   logic rst_n, sample_stb, act_enable, still_enable, wakeup_mode, measure_start, int_release;
   logic spi_sclk, spi_cs_n, spi_mosi, spi_miso_o, spi_miso_oe;
   logic activity_evt, stillness_evt, soft_reset_evt, standby, int_hiz;
   sample_t sample;
   int fail_count = 0, n_checks = 0, cycles = 0, n_act = 0, n_still = 0, n_rst = 0;
   int a0, s0, r0;
   logic [15:0] got;

   always #5 core_clk = ~core_clk;

   motion_detect_register_bank motion_detect_register_bank_i (
      .CORE_CLK(core_clk), .RST_N(rst_n), .SPI_SCLK(spi_sclk), .SPI_CS_N(spi_cs_n),
      .SPI_MOSI(spi_mosi), .SPI_MISO_O(spi_miso_o), .SPI_MISO_OE(spi_miso_oe),
      .SAMPLE_STB(sample_stb), .SAMPLE(sample), .ACT_ENABLE(act_enable),
      .STILL_ENABLE(still_enable), .WAKEUP_MODE(wakeup_mode), .MEASURE_START(measure_start),
      .INT_RELEASE(int_release), .ACTIVITY_EVT(activity_evt), .STILLNESS_EVT(stillness_evt),
      .SOFT_RESET_EVT(soft_reset_evt), .STANDBY(standby), .INT_HIZ(int_hiz));

   spi_host_model spi_host_model_i (
      .CORE_CLK(core_clk), .SPI_SCLK(spi_sclk), .SPI_CS_N(spi_cs_n), .SPI_MOSI(spi_mosi),
      .SPI_MISO_O(spi_miso_o), .SPI_MISO_OE(spi_miso_oe));

   // -----------------------------
   // Monitors and helpers
   // -----------------------------
   always @(posedge core_clk) begin
      if (activity_evt === 1'b1) n_act <= n_act + 1;
      if (stillness_evt === 1'b1) n_still <= n_still + 1;
      if (soft_reset_evt === 1'b1) n_rst <= n_rst + 1;
      cycles <= cycles + 1;
      if (cycles >= LIMIT) begin
         fail_count++;
         $display("wrong value run length expected below %0d seen %0d", LIMIT, cycles);
         finish_test();
      end
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic rd(input logic [7:0] addr, input int n, input logic [15:0] exp);
      spi_host_model_i.frame(CMD_READ, addr, n, 16'h0000, got);
      check($sformatf("offset %h", addr), exp, got);
   endtask : rd

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      spi_host_model_i.frame(CMD_WRITE, addr, 1, {8'h00, data}, got);
   endtask : wr

   task automatic smp(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
      sample <= sample_t'({x, y, z, 12'hFFF, 12'h123});
      sample_stb <= 1'b1;
      @(posedge core_clk);
      sample_stb <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask : smp

   task automatic mark;
      a0 = n_act;
      s0 = n_still;
      r0 = n_rst;
   endtask : mark

   task automatic ev_chk(input int ea, input int es, input int er);
      check("activity events", 16'(ea), 16'(n_act - a0));
      check("stillness events", 16'(es), 16'(n_still - s0));
      check("soft reset events", 16'(er), 16'(n_rst - r0));
   endtask : ev_chk

   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   // -----------------------------
   // Sequence
   // -----------------------------
   initial begin
      rst_n = 1'b0;
      {sample_stb, act_enable, still_enable, wakeup_mode, measure_start, int_release} = '0;
      sample = '0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      check("standby", 16'h0001, 16'(standby));
      for (int a = 'h10; a <= 'h26; a++) rd(8'(a), 1, 16'h0000);
      measure_start <= 1'b1;
      int_release <= 1'b1;
      @(posedge core_clk);
      measure_start <= 1'b0;
      int_release <= 1'b0;
      repeat (2) @(posedge core_clk);
      check("standby", 16'h0000, 16'({standby, int_hiz}));
      wr(OFS_ACT_LIMIT_HIGH, 8'hF9);
      rd(OFS_ACT_LIMIT_LOW, 2, 16'h0100);
      wr(OFS_STILL_LIMIT_LOW, 8'h10);
      wr(OFS_STILL_LIMIT_HIGH, 8'hF8);
      rd(OFS_STILL_LIMIT_LOW, 2, 16'h0010);
      wr(OFS_STILL_DUR_LOW, 8'h01);
      wr(OFS_STILL_DUR_HIGH, 8'h01);
      rd(OFS_STILL_DUR_LOW, 2, 16'h0101);
      smp(12'h000, 12'h800, 12'h7FF);
      wr(OFS_Y_LOW, 8'h55);
      rd(OFS_Y_LOW, 2, 16'hF800);
      rd(OFS_Z_LOW, 2, 16'h07FF);
      rd(OFS_TEMP_LOW, 2, 16'hFFFF);
      rd(OFS_AUX_LOW, 2, 16'h0123);
      // Activity: boundary value, duration zero, then a three-sample run
      act_enable <= 1'b1;
      mark();
      smp(12'h000, 12'h100, 12'h000);
      smp(12'h000, 12'hEFF, 12'h000);
      ev_chk(1, 0, 0);
      wr(OFS_ACT_DURATION, 8'h03);
      mark();
      smp(12'h000, 12'h000, 12'h000);
      smp(12'h101, 12'h000, 12'h000);
      smp(12'h000, 12'h000, 12'hE00);
      smp(12'h000, 12'h000, 12'h000);
      smp(12'h000, 12'h200, 12'h000);
      smp(12'h000, 12'h200, 12'h000);
      ev_chk(0, 0, 0);
      smp(12'h000, 12'h200, 12'h000);
      ev_chk(1, 0, 0);
      smp(12'h000, 12'h000, 12'h000);
      wakeup_mode <= 1'b1;
      mark();
      smp(12'h000, 12'h200, 12'h000);
      ev_chk(1, 0, 0);
      wakeup_mode <= 1'b0;
      smp(12'h000, 12'h000, 12'h000);
      act_enable <= 1'b0;
      mark();
      smp(12'h000, 12'h200, 12'h000);
      ev_chk(0, 0, 0);
      // Stillness: 257 quiet samples after a boundary sample, then duration zero
      still_enable <= 1'b1;
      mark();
      smp(12'h000, 12'hFF0, 12'h000);
      repeat (256) smp(12'hFF1, 12'h000, 12'h000);
      ev_chk(0, 0, 0);
      smp(12'hFF1, 12'h000, 12'h000);
      ev_chk(0, 1, 0);
      wr(OFS_STILL_DUR_LOW, 8'h00);
      wr(OFS_STILL_DUR_HIGH, 8'h00);
      smp(12'h000, 12'h000, 12'h010);
      mark();
      smp(12'h000, 12'h00F, 12'h000);
      ev_chk(0, 1, 0);
      // Software reset: wrong code ignored, right code clears and parks
      still_enable <= 1'b0;
      mark();
      wr(OFS_SOFT_RESET, 8'h51);
      ev_chk(0, 0, 0);
      rd(OFS_ACT_LIMIT_LOW, 2, 16'h0100);
      wr(OFS_SOFT_RESET, SOFT_RESET_CODE);
      ev_chk(0, 0, 1);
      check("standby and floated", 16'h0003, 16'({standby, int_hiz}));
      rd(OFS_ACT_LIMIT_LOW, 2, 16'h0000);
      rd(OFS_ACT_DURATION, 1, 16'h0000);
      rd(OFS_Y_LOW, 2, 16'h0000);
      act_enable <= 1'b1;
      mark();
      smp(12'h000, 12'h7FF, 12'h000);
      ev_chk(0, 0, 0);
      rd(OFS_Y_LOW, 2, 16'h0000);
      finish_test();
   end
endmodule : motion_detect_register_bank_bench
